/* File: rtl/occ_regs.sv */
// Purpose: oscillator control and fast rc tuning registers
// Assumes: status inputs from analog side are asynchronous
// Notes:   clock muxes and dividers themselves live outside this block
`timescale 1ns/100ps
module occ_regs (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata_ff,
    // configuration fuses
    input  wire logic [2:0]  initial_source_fuses,
    input  wire logic [1:0]  switch_monitor_fuses,
    input  wire logic [2:0]  pll_out_divider_fuses,
    input  wire logic [2:0]  pll_multiplier_fuses,
    input  wire logic [1:0]  periph_bus_divisor_fuses,
    input  wire logic        secondary_osc_fuse,
    // analog status
    input  wire logic        sosc_stable,
    input  wire logic        usb_pll_ok,
    input  wire logic        sys_pll_ok,
    input  wire logic        fail_detect,
    input  wire logic        periph_div_busy,
    // control outputs
    output logic [2:0]       pll_out_divider_ff,
    output logic [2:0]       fast_rc_divider_ff,
    output logic [1:0]       periph_bus_divisor_ff,
    output logic [4:0]       pll_factor_ff,
    output logic [2:0]       current_source_ff,
    output logic             sleep_on_wait_ff,
    output logic             usb_rc_source_sel_ff,
    output logic             secondary_osc_enable_ff,
    output logic [5:0]       rc_trim_ff
);
    // ==========================================================
    // synchronisers
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= 5'h00;
            sync_ff <= 5'h00;
        end else begin
            meta_ff <= {sosc_stable, usb_pll_ok, sys_pll_ok, fail_detect, periph_div_busy};
            sync_ff <= meta_ff;
        end
    end

    // ==========================================================
    // address decode and alias merge
    logic [1:0]  alias_sel;
    logic [7:0]  base_addr;
    logic        hit_ctrl;
    logic        hit_tune;
    logic        hit_key;
    logic [31:0] ctrl_view;
    logic [31:0] tune_view;
    logic [31:0] ctrl_new;
    logic [31:0] tune_new;
    assign alias_sel = addr[3:2];
    assign base_addr = {addr[7:4], 4'h0};
    assign hit_ctrl  = (base_addr == occ_pkg::OCC_CTRL_ADDR);
    assign hit_tune  = (base_addr == occ_pkg::OCC_TUNE_ADDR);
    assign hit_key   = (addr == occ_pkg::OCC_KEY_ADDR);

    function automatic logic [31:0] merge(input logic [1:0] sel, input logic [31:0] cur,
                                          input logic [31:0] d);
        unique case (sel)
            occ_pkg::OCC_ALIAS_WR:  merge = d;
            occ_pkg::OCC_ALIAS_CLR: merge = cur & ~d;
            occ_pkg::OCC_ALIAS_SET: merge = cur | d;
            occ_pkg::OCC_ALIAS_INV: merge = cur ^ d;
        endcase
    endfunction

    assign ctrl_new = merge(alias_sel, ctrl_view, wdata);
    assign tune_new = merge(alias_sel, tune_view, wdata);

    // ==========================================================
    // unlock key sequence: two key words, then one register write
    logic key_half_ff;
    logic unlocked_ff;
    logic reg_wr;
    assign reg_wr = wr && unlocked_ff && (hit_ctrl || hit_tune);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            key_half_ff <= 1'b0;
            unlocked_ff <= 1'b0;
        end else if (wr) begin
            key_half_ff <= hit_key && (wdata == occ_pkg::OCC_KEY_ONE);
            unlocked_ff <= hit_key && key_half_ff && (wdata == occ_pkg::OCC_KEY_TWO);
        end
    end

    // ==========================================================
    // fuse capture after reset release
    logic       fuse_load_ff;
    logic [1:0] monitor_fuses_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fuse_load_ff     <= 1'b1;
            monitor_fuses_ff <= 2'h0;
        end else begin
            fuse_load_ff <= 1'b0;
            if (fuse_load_ff) begin
                monitor_fuses_ff <= switch_monitor_fuses;
            end
        end
    end

    // ==========================================================
    // selection lock
    logic lock_ff;
    logic frozen;
    assign frozen = lock_ff && monitor_fuses_ff[1];
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lock_ff <= 1'b0;
        end else if (reg_wr && hit_ctrl) begin
            lock_ff <= ctrl_new[occ_pkg::OCC_LOCK_BIT] | lock_ff;
        end
    end

    // ==========================================================
    // clock and pll selection fields
    logic [2:0] mult_code_ff;
    logic [2:0] req_src_ff;
    logic       sel_wr;
    assign sel_wr = reg_wr && hit_ctrl && !frozen;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pll_out_divider_ff <= 3'h0;
            mult_code_ff       <= occ_pkg::OCC_MULT_BASE;
            req_src_ff         <= 3'h0;
        end else if (fuse_load_ff) begin
            pll_out_divider_ff <= pll_out_divider_fuses;
            mult_code_ff       <= pll_multiplier_fuses;
            req_src_ff         <= initial_source_fuses;
        end else if (sel_wr) begin
            pll_out_divider_ff <= ctrl_new[occ_pkg::OCC_ODIV_LSB +: 3];
            mult_code_ff       <= ctrl_new[occ_pkg::OCC_MULT_LSB +: 3];
            req_src_ff         <= ctrl_new[occ_pkg::OCC_REQ_LSB +: 3];
        end
    end

    // multiplier factor 15 plus code
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pll_factor_ff <= occ_pkg::OCC_MULT_LOW;
        end else begin
            pll_factor_ff <= occ_pkg::OCC_MULT_LOW + {2'h0, mult_code_ff};
        end
    end

    // ==========================================================
    // other control bits
    logic periph_writable;
    assign periph_writable = !sync_ff[0];
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fast_rc_divider_ff      <= occ_pkg::OCC_RDIV_RST;
            periph_bus_divisor_ff   <= occ_pkg::OCC_PDIV_RST;
            sleep_on_wait_ff        <= 1'b0;
            usb_rc_source_sel_ff    <= 1'b0;
            secondary_osc_enable_ff <= 1'b0;
        end else if (fuse_load_ff) begin
            periph_bus_divisor_ff   <= periph_bus_divisor_fuses;
            secondary_osc_enable_ff <= secondary_osc_fuse;
        end else if (reg_wr && hit_ctrl) begin
            fast_rc_divider_ff      <= ctrl_new[occ_pkg::OCC_RDIV_LSB +: 3];
            if (periph_writable) begin
                periph_bus_divisor_ff <= ctrl_new[occ_pkg::OCC_PDIV_LSB +: 2];
            end
            sleep_on_wait_ff        <= ctrl_new[occ_pkg::OCC_SLP_BIT];
            usb_rc_source_sel_ff    <= ctrl_new[occ_pkg::OCC_URC_BIT];
            secondary_osc_enable_ff <= ctrl_new[occ_pkg::OCC_SEN_BIT];
        end
    end

    // ==========================================================
    // clock fail flag: detection wins over software clear
    logic fail_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fail_ff <= 1'b0;
        end else if (sync_ff[1]) begin
            fail_ff <= 1'b1;
        end else if (reg_wr && hit_ctrl) begin
            fail_ff <= ctrl_new[occ_pkg::OCC_FAIL_BIT];
        end
    end

    // ==========================================================
    // clock switch sequencer
    typedef enum logic [1:0] {
        OCC_IDLE = 2'b01,
        OCC_WAIT = 2'b10
    } occ_sw_type;
    occ_sw_type sw_state_ff;
    logic [3:0] sw_cnt_ff;
    logic       sw_start_ff;
    logic       sw_done;
    assign sw_done = (sw_state_ff == OCC_WAIT) && (sw_cnt_ff == 4'h0);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sw_state_ff <= OCC_IDLE;
            sw_cnt_ff   <= 4'h0;
        end else begin
            unique case (sw_state_ff)
                OCC_IDLE: begin
                    if (sw_start_ff) begin
                        sw_state_ff <= OCC_WAIT;
                        sw_cnt_ff   <= 4'(occ_pkg::OCC_SWITCH_CYCLES - 1);
                    end
                end
                OCC_WAIT: begin
                    if (sw_cnt_ff == 4'h0) begin
                        sw_state_ff <= OCC_IDLE;
                    end else begin
                        sw_cnt_ff <= sw_cnt_ff - 4'h1;
                    end
                end
            endcase
        end
    end

    // start bit and current source
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sw_start_ff       <= 1'b0;
            current_source_ff <= 3'h0;
        end else if (fuse_load_ff) begin
            current_source_ff <= initial_source_fuses;
        end else if (sw_done) begin
            sw_start_ff       <= 1'b0;
            current_source_ff <= req_src_ff;
        end else if (sel_wr && ctrl_new[occ_pkg::OCC_SW_BIT]) begin
            sw_start_ff <= 1'b1;
        end
    end

    // ==========================================================
    // tuning register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rc_trim_ff <= occ_pkg::OCC_TUNE_RST;
        end else if (reg_wr && hit_tune) begin
            rc_trim_ff <= tune_new[5:0];
        end
    end

    // ==========================================================
    // read views
    always_comb begin
        ctrl_view = 32'h0000_0000;
        ctrl_view[occ_pkg::OCC_ODIV_LSB +: 3] = pll_out_divider_ff;
        ctrl_view[occ_pkg::OCC_RDIV_LSB +: 3] = fast_rc_divider_ff;
        ctrl_view[occ_pkg::OCC_SRDY_BIT]      = sync_ff[4] & secondary_osc_enable_ff;
        ctrl_view[occ_pkg::OCC_PWOK_BIT]      = periph_writable;
        ctrl_view[occ_pkg::OCC_PDIV_LSB +: 2] = periph_bus_divisor_ff;
        ctrl_view[occ_pkg::OCC_MULT_LSB +: 3] = mult_code_ff;
        ctrl_view[occ_pkg::OCC_CUR_LSB +: 3]  = current_source_ff;
        ctrl_view[occ_pkg::OCC_REQ_LSB +: 3]  = req_src_ff;
        ctrl_view[occ_pkg::OCC_LOCK_BIT]      = lock_ff;
        ctrl_view[occ_pkg::OCC_ULCK_BIT]      = sync_ff[3];
        ctrl_view[occ_pkg::OCC_SLCK_BIT]      = sync_ff[2];
        ctrl_view[occ_pkg::OCC_SLP_BIT]       = sleep_on_wait_ff;
        ctrl_view[occ_pkg::OCC_FAIL_BIT]      = fail_ff;
        ctrl_view[occ_pkg::OCC_URC_BIT]       = usb_rc_source_sel_ff;
        ctrl_view[occ_pkg::OCC_SEN_BIT]       = secondary_osc_enable_ff;
        ctrl_view[occ_pkg::OCC_SW_BIT]        = sw_start_ff;
        tune_view = {26'h000_0000, rc_trim_ff};
    end

    // read data, one cycle after the strobe, zero elsewhere
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd && hit_ctrl) begin
            rdata_ff <= ctrl_view;
        end else if (rd && hit_tune) begin
            rdata_ff <= tune_view;
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end
endmodule

/* File: rtl/occ_pkg.sv */
// Purpose: constants for the oscillator control register block
// Assumes: word-addressed plain register port, byte addresses below
// Notes:   reset values of fuse-backed fields come from strap inputs
// How it works
// - pll output divider code 0..7 selects divide 1,2,4,8,16,32,64,256
// - rc divider code 0..7 selects divide 1..256, reset code 001
// - bit 22 reads 1 only while the secondary oscillator is stable
// - bit 21 tells software the bus divisor may be written
// - bus divisor codes 00..11 divide system clock by 1,2,4,8, reset value loaded from fuses
// - pll multiplier code 000..101 gives 15..20
// - bits 14-12 report the active clock source code
// - bits 10-8 hold requested source, loaded from fuses at reset
// - fuses 1x let the lock bit freeze selections, 0x never lock
// - bit 6 shows usb pll locked or start-up done
// - bit 5 shows system pll locked or start-up done
// - bit 4 picks sleep when set, idle when clear, on wait
// - bit 3 sets when a clock failure is detected
// - bit 2 routes the rc oscillator to the usb clock
// - bit 1 enables the secondary oscillator
// - writing 1 to bit 0 starts a switch, reads 0 when done
// - writes without a preceding unlock are ignored
// - six-bit signed trim of the rc frequency
// - tuning register bits 31-6 read zero
// - clear, set and invert aliases sit at +4, +8, +12
package occ_pkg;
    localparam logic [7:0]  OCC_CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  OCC_TUNE_ADDR   = 8'h10;
    localparam logic [7:0]  OCC_KEY_ADDR    = 8'h20;
    localparam logic [31:0] OCC_KEY_ONE     = 32'hAA99_6655;
    localparam logic [31:0] OCC_KEY_TWO     = 32'h5566_99AA;
    localparam logic [1:0]  OCC_ALIAS_WR    = 2'h0;
    localparam logic [1:0]  OCC_ALIAS_CLR   = 2'h1;
    localparam logic [1:0]  OCC_ALIAS_SET   = 2'h2;
    localparam logic [1:0]  OCC_ALIAS_INV   = 2'h3;
    // field positions in the control register
    localparam int OCC_ODIV_LSB  = 27;
    localparam int OCC_RDIV_LSB  = 24;
    localparam int OCC_SRDY_BIT  = 22;
    localparam int OCC_PWOK_BIT  = 21;
    localparam int OCC_PDIV_LSB  = 19;
    localparam int OCC_MULT_LSB  = 16;
    localparam int OCC_CUR_LSB   = 12;
    localparam int OCC_REQ_LSB   = 8;
    localparam int OCC_LOCK_BIT  = 7;
    localparam int OCC_ULCK_BIT  = 6;
    localparam int OCC_SLCK_BIT  = 5;
    localparam int OCC_SLP_BIT   = 4;
    localparam int OCC_FAIL_BIT  = 3;
    localparam int OCC_URC_BIT   = 2;
    localparam int OCC_SEN_BIT   = 1;
    localparam int OCC_SW_BIT    = 0;
    // reset values
    localparam logic [2:0] OCC_RDIV_RST = 3'h1;
    localparam logic [1:0] OCC_PDIV_RST = 2'h3;
    localparam logic [2:0] OCC_MULT_BASE = 3'h0;
    localparam logic [4:0] OCC_MULT_LOW  = 5'h0F;
    localparam logic [5:0] OCC_TUNE_RST  = 6'h00;
    // switch settle time before the new source is reported
    localparam int OCC_SWITCH_NS     = 40;
    localparam int OCC_CLK_NS        = 8;
    localparam int OCC_SWITCH_CYCLES = (OCC_SWITCH_NS + OCC_CLK_NS - 1) / OCC_CLK_NS;
endpackage

/* File: dv/occ_regs_sva.sv */
// Purpose: port assertions for the oscillator control registers
// Assumes: one clock domain, nrst async active low
// Notes:   read data is judged in the cycle after rd
`timescale 1ns/100ps
module occ_regs_sva (
    // clock and register port
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata_ff,
    // control outputs
    input wire logic [2:0]  pll_out_divider_ff,
    input wire logic [2:0]  fast_rc_divider_ff,
    input wire logic [1:0]  periph_bus_divisor_ff,
    input wire logic [4:0]  pll_factor_ff,
    input wire logic        sleep_on_wait_ff,
    input wire logic        usb_rc_source_sel_ff,
    input wire logic        secondary_osc_enable_ff,
    input wire logic [5:0]  rc_trim_ff,
    input wire logic [2:0]  current_source_ff
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // ========================================
    // unlock tracking, bit 1 opens the next write
    logic       key_wr;
    logic [1:0] key_ff;
    assign key_wr = wr && addr == occ_pkg::OCC_KEY_ADDR;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            key_ff <= 2'h0;
        end else if (wr) begin
            key_ff[0] <= key_wr && wdata == occ_pkg::OCC_KEY_ONE;
            key_ff[1] <= key_wr && wdata == occ_pkg::OCC_KEY_TWO && key_ff[0];
        end
    end
    sequence s_unlock;
        key_wr && wdata == occ_pkg::OCC_KEY_ONE ##1 key_wr && wdata == occ_pkg::OCC_KEY_TWO;
    endsequence
    sequence s_rd_ctrl;
        rd && addr == occ_pkg::OCC_CTRL_ADDR;
    endsequence
    // ========================================
    // assertions
    chk_rdata_idle: assert property (!rd |=> rdata_ff == 32'h0000_0000)
        else $error("read data not zero outside a read");
    chk_pll_factor: assert property (s_rd_ctrl |=> pll_factor_ff == 5'h0F + rdata_ff[18:16])
        else $error("pll factor differs from multiplier code");
    chk_cur_source: assert property (s_rd_ctrl |=> rdata_ff[14:12] == $past(current_source_ff))
        else $error("current source output differs from read");
    chk_ctrl_fields: assert property (s_rd_ctrl |=> rdata_ff[29:27] == pll_out_divider_ff
        && rdata_ff[26:24] == fast_rc_divider_ff && rdata_ff[20:19] == periph_bus_divisor_ff)
        else $error("divider fields differ from outputs");
    chk_ctrl_bits: assert property (s_rd_ctrl |=> rdata_ff[4] == sleep_on_wait_ff
        && rdata_ff[2] == usb_rc_source_sel_ff && rdata_ff[1] == secondary_osc_enable_ff
        && (rdata_ff[22] -> rdata_ff[1]) && rdata_ff[31:30] == 2'h0 && !rdata_ff[23]
        && !rdata_ff[15] && !rdata_ff[11])
        else $error("control bits differ from outputs");
    chk_tune_view: assert property (rd && addr == occ_pkg::OCC_TUNE_ADDR |=>
        rdata_ff[31:6] == 26'h000_0000 && rdata_ff[5:0] == rc_trim_ff)
        else $error("tuning read wrong");
    chk_locked_out: assert property (wr && addr[7:5] == 3'h0 && !key_ff[1] |=>
        $stable(sleep_on_wait_ff) && $stable(rc_trim_ff) && $stable(secondary_osc_enable_ff))
        else $error("write without unlock took effect");
    chk_unlock_write: assert property (s_unlock ##1 wr && addr == occ_pkg::OCC_CTRL_ADDR |=>
        sleep_on_wait_ff == $past(wdata[4]) && secondary_osc_enable_ff == $past(wdata[1]))
        else $error("unlocked control write not applied");
    chk_tune_write: assert property (s_unlock ##1 wr && addr == occ_pkg::OCC_TUNE_ADDR |=>
        rc_trim_ff == $past(wdata[5:0]))
        else $error("unlocked tuning write not applied");
    chk_pdiv_cause: assert property ($changed(periph_bus_divisor_ff) && $past(nrst, 2) |->
        $past(wr) && $past(key_ff[1]) && $past(addr[7:4]) == 4'h0)
        else $error("bus divisor changed without a write");
endmodule
bind occ_regs occ_regs_sva chk (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata_ff), .pll_out_divider_ff(pll_out_divider_ff),
    .fast_rc_divider_ff(fast_rc_divider_ff), .periph_bus_divisor_ff(periph_bus_divisor_ff),
    .pll_factor_ff(pll_factor_ff), .sleep_on_wait_ff(sleep_on_wait_ff),
    .usb_rc_source_sel_ff(usb_rc_source_sel_ff),
    .secondary_osc_enable_ff(secondary_osc_enable_ff), .rc_trim_ff(rc_trim_ff),
    .current_source_ff(current_source_ff)
);

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for the oscillator control registers
// Assumes: a register model here predicts every read
// Notes:   two reset phases, selection lock armed then disarmed by fuse
`timescale 1ns/100ps
module tb_top;
    // ========================================
    // stimulus and model state
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_seen = 1'b0;
    logic [31:0] rdata;
    logic [2:0]  f_src = 3'h0;
    logic [2:0]  f_odiv = 3'h0;
    logic [2:0]  f_mult = 3'h0;
    logic [1:0]  f_mon = 2'h0;
    logic [1:0]  f_pdiv = 2'h0;
    logic        f_sen = 1'b0;
    logic [4:0]  st = 5'h00;   // sosc, usb pll, sys pll, fail, busy
    logic [31:0] m_ctrl, m_tune, r, d, e;
    logic [31:0] seed = 32'h84d8_3af7;
    logic [31:0] exp_q[$];
    int          m_k, checks, miscompares;
    always #4 mclk = ~mclk;
    occ_regs dut (
        .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_ff(rdata), .initial_source_fuses(f_src), .switch_monitor_fuses(f_mon),
        .pll_out_divider_fuses(f_odiv), .pll_multiplier_fuses(f_mult),
        .periph_bus_divisor_fuses(f_pdiv), .secondary_osc_fuse(f_sen),
        .sosc_stable(st[4]), .usb_pll_ok(st[3]), .sys_pll_ok(st[2]), .fail_detect(st[1]),
        .periph_div_busy(st[0]), .pll_out_divider_ff(), .fast_rc_divider_ff(),
        .periph_bus_divisor_ff(), .pll_factor_ff(), .current_source_ff(),
        .sleep_on_wait_ff(), .usb_rc_source_sel_ff(), .secondary_osc_enable_ff(),
        .rc_trim_ff()
    );
    // ========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] view();
        logic [31:0] v;
        v = m_ctrl;
        v[22] = st[4] & m_ctrl[1];
        v[21] = ~st[0];
        v[6]  = st[3];
        v[5]  = st[2];
        return v;
    endfunction
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge mclk);
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] x);
        @(posedge mclk);
        addr <= a;
        wr   <= 1'b0;
        rd   <= 1'b1;
        exp_q.push_back(x);
    endtask
    // write, then fold its effect into the model
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] o, n, m;
        @(posedge mclk);
        addr  <= a;
        wdata <= x;
        wr    <= 1'b1;
        rd    <= 1'b0;
        o = a[4] ? m_tune : m_ctrl;
        n = a[3] ? (a[2] ? o ^ x : o | x) : (a[2] ? o & ~x : x);
        m = a[4] ? 32'h0000_003F : 32'h3F1F_079F;
        if (!a[4] && f_mon[1] && m_ctrl[7]) m = m & ~32'h3807_0701;
        if (!a[4] && st[0]) m = m & ~32'h0018_0000;
        n = (o & ~m) | (n & m);
        n[7] = n[7] | o[7];   // lock only clears on reset
        if (m_k == 2 && a[7:4] == 4'h1) m_tune = n;
        if (m_k == 2 && a[7:4] == 4'h0) m_ctrl = n | {28'h0, st[1], 3'h0};
        m_k = (a == occ_pkg::OCC_KEY_ADDR && x == occ_pkg::OCC_KEY_TWO && m_k == 1) ? 2 :
              (a == occ_pkg::OCC_KEY_ADDR && x == occ_pkg::OCC_KEY_ONE) ? 1 : 0;
    endtask
    task automatic unlock();
        wr_reg(occ_pkg::OCC_KEY_ADDR, occ_pkg::OCC_KEY_ONE);
        wr_reg(occ_pkg::OCC_KEY_ADDR, occ_pkg::OCC_KEY_TWO);
    endtask
    // pending switch: see it busy, let it settle, then expect the new source
    task automatic sw_wait();
        if (m_ctrl[0]) begin
            rd_reg(occ_pkg::OCC_CTRL_ADDR, view());
            idle(12);
            m_ctrl[14:12] = m_ctrl[10:8];
            m_ctrl[0] = 1'b0;
        end
    endtask
    task automatic do_reset(input logic [1:0] mon);
        idle(2);
        nrst <= 1'b0;
        r = rnd();
        {f_src, f_odiv, f_mult, f_pdiv, f_sen} <= r[11:0];
        f_mon <= mon;
        idle(4);
        nrst <= 1'b1;
        m_ctrl = {2'h0, f_odiv, 3'h1, 3'h0, f_pdiv, f_mult, 1'b0, f_src, 1'b0, f_src, 6'h00,
                  f_sen, 1'b0};
        m_tune = 32'h0000_0000;
        m_k = 0;
        idle(1);
    endtask
    task automatic test_done();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ========================================
    // read monitor, oldest expectation first
    always @(posedge mclk) rd_seen <= rd;
    always @(negedge mclk) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            checks++;
            if (rdata !== e) begin
                miscompares++;
                $display("BAD t=%0t got=%h exp=%h", $time, rdata, e);
            end
        end
    end
    // ========================================
    // main sequence and hang guard
    initial begin
        for (int ph = 0; ph < 2; ph++) begin
            do_reset(ph ? 2'h1 : 2'h2);
            rd_reg(occ_pkg::OCC_CTRL_ADDR, view());
            rd_reg(occ_pkg::OCC_TUNE_ADDR, 32'h0000_0000);
            rd_reg(8'h30, 32'h0000_0000);
            wr_reg(occ_pkg::OCC_CTRL_ADDR, ~m_ctrl);
            unlock();
            wr_reg(8'h30, 32'hFFFF_FFFF);
            wr_reg(occ_pkg::OCC_TUNE_ADDR, 32'hFFFF_FFFF);
            for (int i = 0; i < 48; i++) begin
                r = rnd();
                st <= {r[20:18], r[17] & r[16], r[15]};
                idle(3);
                m_ctrl[3] = m_ctrl[3] | st[1];
                d = rnd();
                d[7] = i >= 32;
                unlock();
                wr_reg({3'h0, r[4:2], 2'h0}, d);
                sw_wait();
                rd_reg(occ_pkg::OCC_CTRL_ADDR, view());
                rd_reg(occ_pkg::OCC_TUNE_ADDR, m_tune);
            end
        end
        idle(3);
        test_done();
    end
    initial begin
        for (int c = 0; c < 50000; c++) @(posedge mclk);
        miscompares++;
        test_done();
    end
endmodule
